/* logic/bdm_pkg.sv */
// constants and types shared by the banked data memory and table-read block
package bdm_pkg;
	// data memory geometry
	localparam logic [7:0]  SR_END          = 8'h3F;
	localparam logic [7:0]  GEN_BASE        = 8'h40;
	localparam logic [7:0]  GEN_END         = 8'hFF;
	localparam int          GEN_BANK_SIZE   = 192;
	localparam int          GEN_BANKS       = 6;
	localparam int          GEN_AW          = 11;
	localparam logic [7:0]  DISP_BANK       = 8'h01;
	localparam logic [7:0]  LAST_BANK       = 8'h06;
	localparam logic [7:0]  DISP_END_NARROW = 8'h70;
	localparam logic [7:0]  DISP_END_WIDE   = 8'h9F;
	// special region locations
	localparam logic [5:0]  ADDR_BANK_SEL   = 6'h04;
	localparam logic [5:0]  ADDR_TABLE_PTR  = 6'h07;
	localparam logic [5:0]  ADDR_HIGH_LATCH = 6'h08;
	localparam logic [5:0]  ADDR_UNUSED_A   = 6'h1F;
	localparam logic [5:0]  ADDR_UNUSED_B   = 6'h3E;
	localparam logic [5:0]  ADDR_UNUSED_C   = 6'h3F;
	localparam int          SR_DEPTH        = 64;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [7:0]  BIT0_MASK       = 8'h01;
	// program memory
	localparam int          PM_AW           = 14;
	localparam logic [13:0] LAST_PAGE_BASE  = 14'h3F00;

	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_SET,
		OP_CLR,
		OP_TBL_CUR,
		OP_TBL_LAST
	} bdm_op_t;

	typedef enum logic {
		ST_IDLE,
		ST_TABLE
	} bdm_state_t;

	typedef enum logic [1:0] {
		RG_SPECIAL,
		RG_GENERAL,
		RG_DISPLAY,
		RG_NONE
	} bdm_region_t;
endpackage : bdm_pkg

/* logic/bdm_ram.sv */
// byte-wide storage with one write port and two asynchronous read ports
`timescale 1ns/10ps
module bdm_ram #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// clock
	input  wire logic          clock_in,
	// write port
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [7:0]    wr_data_in,
	// read ports
	input  wire logic [AW-1:0] rd_a_addr_in,
	output logic      [7:0]    rd_a_data_out,
	input  wire logic [AW-1:0] rd_b_addr_in,
	output logic      [7:0]    rd_b_data_out
);
	// every location is one whole byte
	logic [7:0] mem_reg [DEPTH];

	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end

	assign rd_a_data_out = mem_reg[rd_a_addr_in];
	assign rd_b_data_out = mem_reg[rd_b_addr_in];
endmodule : bdm_ram

/* logic/bdm_core.sv */
// banked data memory decode with program-memory table reads
// Contract
// - last-page read fetches from page 3F00H
// - current-page read uses present PC page
// - every table read loads high-byte latch
// - high-byte latch read-only, changed by tables
// - table instructions take two cycles
// - all banks are byte-wide RAM
// - 00H-3FH special region in every bank
// - banks 0,2-6 hold RAM 40H-FFH
// - bank 1 holds display memory 40H-end
// - bank selection alone picks display or RAM
// - bank select steers non-special accesses
// - display output is a registered scan of the stored display bytes
// - single-bit set and clear on any location
// - some special registers are write-protected
// - table pointer gives low address byte
// - latch bits without program bits read zero
// - unused special locations read 00H
`timescale 1ns/10ps
module bdm_core
	import bdm_pkg::*;
#(
	parameter logic [7:0] DISP_END  = DISP_END_WIDE,
	parameter logic [7:0] HIGH_MASK = 8'hFF,
	parameter int         DISP_AW   = 7
) (
	// clock and reset
	input  wire logic               clock_in,
	input  wire logic               srst_in,
	// operation request from the core
	input  wire logic               op_valid_in,
	input  wire bdm_op_t            op_code_in,
	input  wire logic [7:0]         addr_in,
	input  wire logic [7:0]         data_in,
	input  wire logic [2:0]         bit_in,
	input  wire logic [PM_AW-1:0]   pc_in,
	output logic                    ready_out,
	output logic                    done_out,
	output logic      [7:0]         rdata_out,
	// program memory fetch
	output logic      [PM_AW-1:0]   pm_addr_out,
	output logic                    pm_rd_out,
	input  wire logic [15:0]        pm_data_in,
	// display scan port
	input  wire logic [DISP_AW-1:0] disp_addr_in,
	output logic      [7:0]         disp_data_out,
	// visible state
	output logic      [7:0]         bank_select_out,
	output logic      [7:0]         high_byte_latch_out
);
	localparam int DISP_DEPTH = int'(DISP_END) - int'(GEN_BASE) + 1;
	localparam int GEN_DEPTH  = GEN_BANKS * GEN_BANK_SIZE;

	bdm_state_t  state_reg;
	bdm_state_t  state_next;
	logic [7:0]  sfr_reg [SR_DEPTH];
	logic [7:0]  high_byte_latch_reg;
	logic [7:0]  dest_reg;
	logic [PM_AW-1:0] pm_addr_reg;
	logic        pm_rd_reg;
	logic        done_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  disp_data_reg;

	// which storage a byte address reaches in the given bank
	function automatic bdm_region_t region_of(input logic [7:0] addr, input logic [7:0] bank);
		bdm_region_t r;
		r = RG_NONE;
		if (addr <= SR_END) begin
			r = RG_SPECIAL;
		end else if (bank == DISP_BANK) begin
			r = (addr <= DISP_END) ? RG_DISPLAY : RG_NONE;
		end else if (bank <= LAST_BANK && addr <= GEN_END) begin
			r = RG_GENERAL;
		end
		return r;
	endfunction : region_of

	// banks 0,2..6 pack into one array; bank 1 is absent from it
	function automatic logic [GEN_AW-1:0] gen_index(input logic [7:0] addr,
		input logic [7:0] bank);
		logic [GEN_AW-1:0] slot;
		slot = (bank == 8'h00) ? '0 : GEN_AW'(bank - 8'h01);
		return GEN_AW'(slot * GEN_AW'(GEN_BANK_SIZE)) + GEN_AW'(addr - GEN_BASE);
	endfunction : gen_index

	function automatic logic sr_unused(input logic [5:0] a);
		return a == ADDR_UNUSED_A || a == ADDR_UNUSED_B || a == ADDR_UNUSED_C;
	endfunction : sr_unused

	function automatic logic sr_read_only(input logic [5:0] a);
		return a == ADDR_HIGH_LATCH;
	endfunction : sr_read_only

	// request decode
	wire logic        accept     = (state_reg == ST_IDLE) && op_valid_in;
	wire logic        is_tbl     = (op_code_in == OP_TBL_CUR) || (op_code_in == OP_TBL_LAST);
	wire logic        is_wr_op   = (op_code_in == OP_WRITE) || (op_code_in == OP_SET)
		|| (op_code_in == OP_CLR);
	wire logic        in_table   = (state_reg == ST_TABLE);
	wire logic [7:0]  bank_sel   = sfr_reg[ADDR_BANK_SEL];
	wire logic [7:0]  table_ptr  = sfr_reg[ADDR_TABLE_PTR];

	// read path, shared by plain reads and bit operations
	wire bdm_region_t rd_region  = region_of(addr_in, bank_sel);
	wire logic [5:0]  rd_sr_addr = addr_in[5:0];
	wire logic [7:0]  gen_rd_data;
	wire logic [7:0]  disp_rd_data;
	wire logic [7:0]  disp_scan_data;
	wire logic [7:0]  sr_rd_data = sr_unused(rd_sr_addr) ? ZERO_BYTE :
		(rd_sr_addr == ADDR_HIGH_LATCH) ? high_byte_latch_reg : sfr_reg[rd_sr_addr];
	wire logic [7:0]  rd_byte    = (rd_region == RG_SPECIAL) ? sr_rd_data :
		(rd_region == RG_GENERAL) ? gen_rd_data :
		(rd_region == RG_DISPLAY) ? disp_rd_data : ZERO_BYTE;

	// bit operations change only the addressed bit
	wire logic [7:0]  bit_mask   = BIT0_MASK << bit_in;
	wire logic [7:0]  op_data    = (op_code_in == OP_SET) ? (rd_byte | bit_mask) :
		(op_code_in == OP_CLR) ? (rd_byte & ~bit_mask) : data_in;

	// write path; the second table cycle stores the low byte
	wire logic        wr_fire    = in_table || (accept && is_wr_op);
	wire logic [7:0]  wr_addr    = in_table ? dest_reg : addr_in;
	wire logic [7:0]  wr_data    = in_table ? pm_data_in[7:0] : op_data;
	wire bdm_region_t wr_region  = region_of(wr_addr, bank_sel);
	wire logic [5:0]  wr_sr_addr = wr_addr[5:0];
	wire logic        sr_wr      = wr_fire && (wr_region == RG_SPECIAL)
		&& !sr_read_only(wr_sr_addr) && !sr_unused(wr_sr_addr);
	wire logic        gen_wr     = wr_fire && (wr_region == RG_GENERAL);
	wire logic        disp_wr    = wr_fire && (wr_region == RG_DISPLAY);

	wire logic [PM_AW-1:0] last_addr = {LAST_PAGE_BASE[PM_AW-1:8], table_ptr};
	wire logic [PM_AW-1:0] cur_addr  = {pc_in[PM_AW-1:8], table_ptr};

	// storage arrays, byte wide throughout
	bdm_ram #(.DEPTH(GEN_DEPTH), .AW(GEN_AW)) u_general (
		.clock_in      (clock_in),
		.wr_en_in      (gen_wr),
		.wr_addr_in    (gen_index(wr_addr, bank_sel)),
		.wr_data_in    (wr_data),
		.rd_a_addr_in  (gen_index(addr_in, bank_sel)),
		.rd_a_data_out (gen_rd_data),
		.rd_b_addr_in  ('0),
		.rd_b_data_out ()
	);

	// second read port scans the display straight from the stored bytes
	bdm_ram #(.DEPTH(DISP_DEPTH), .AW(DISP_AW)) u_display (
		.clock_in      (clock_in),
		.wr_en_in      (disp_wr),
		.wr_addr_in    (DISP_AW'(wr_addr - GEN_BASE)),
		.wr_data_in    (wr_data),
		.rd_a_addr_in  (DISP_AW'(addr_in - GEN_BASE)),
		.rd_a_data_out (disp_rd_data),
		.rd_b_addr_in  (disp_addr_in),
		.rd_b_data_out (disp_scan_data)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (accept && is_tbl) begin
					state_next = ST_TABLE;
				end
			end
			ST_TABLE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// special registers; bank select among them comes up as bank 0
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			for (int i = 0; i < SR_DEPTH; i++) begin
				sfr_reg[i] <= RESET_BYTE;
			end
		end else if (sr_wr) begin
			sfr_reg[wr_sr_addr] <= wr_data;
		end
	end

	// latch is loaded by the table cycle only, never by a store
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			high_byte_latch_reg <= RESET_BYTE;
		end else if (in_table) begin
			high_byte_latch_reg <= pm_data_in[15:8] & HIGH_MASK;
		end
	end

	// fetch address is issued at acceptance; program memory answers next cycle
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pm_addr_reg <= '0;
			pm_rd_reg   <= 1'b0;
			dest_reg    <= RESET_BYTE;
		end else begin
			pm_rd_reg <= accept && is_tbl;
			if (accept && is_tbl) begin
				pm_addr_reg <= (op_code_in == OP_TBL_LAST) ? last_addr : cur_addr;
				dest_reg    <= addr_in;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			done_reg      <= 1'b0;
			rdata_reg     <= RESET_BYTE;
			disp_data_reg <= RESET_BYTE;
		end else begin
			done_reg      <= (accept && !is_tbl) || in_table;
			disp_data_reg <= disp_scan_data;
			if (accept && op_code_in == OP_READ) begin
				rdata_reg <= rd_byte;
			end
		end
	end

	assign ready_out           = (state_reg == ST_IDLE);
	assign done_out            = done_reg;
	assign rdata_out           = rdata_reg;
	assign pm_addr_out         = pm_addr_reg;
	assign pm_rd_out           = pm_rd_reg;
	assign disp_data_out       = disp_data_reg;
	assign bank_select_out     = bank_sel;
	assign high_byte_latch_out = high_byte_latch_reg;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	sequence tbl_issue;
		accept && is_tbl;
	endsequence

	sequence tbl_finish;
		in_table && !ready_out ##1 done_out && ready_out;
	endsequence

	chk_table_two_cycles: assert property (tbl_issue |=> tbl_finish)
		else $error("table read did not finish in two cycles");
	chk_last_page_addr: assert property (accept && op_code_in == OP_TBL_LAST |=>
		pm_addr_out == {LAST_PAGE_BASE[PM_AW-1:8], $past(table_ptr)} && pm_rd_out)
		else $error("last page fetch address wrong");
	chk_cur_page_addr: assert property (accept && op_code_in == OP_TBL_CUR |=>
		pm_addr_out[PM_AW-1:8] == $past(pc_in[PM_AW-1:8])
		&& pm_addr_out[7:0] == $past(table_ptr))
		else $error("current page fetch address wrong");
	chk_latch_load: assert property (in_table |=>
		high_byte_latch_out == ($past(pm_data_in[15:8]) & HIGH_MASK))
		else $error("high byte latch not loaded");
	chk_latch_hold: assert property (!in_table |=> $stable(high_byte_latch_out))
		else $error("high byte latch changed outside table read");
	chk_bank_reset: assert property ($fell(srst_in) |-> bank_select_out == 8'h00)
		else $error("bank select not zero after reset");
	chk_unused_zero: assert property (accept && op_code_in == OP_READ
		&& addr_in <= SR_END && sr_unused(addr_in[5:0]) |=> done_out && rdata_out == 8'h00)
		else $error("unused special location read nonzero");
	chk_common_bank: assert property (accept && op_code_in == OP_READ
		&& addr_in[7:0] == {2'b00, ADDR_BANK_SEL} |=> rdata_out == $past(bank_sel))
		else $error("special region not common to banks");
	chk_bit_only: assert property (accept && (op_code_in == OP_SET || op_code_in == OP_CLR)
		&& rd_region == RG_SPECIAL && sr_wr |=>
		((sfr_reg[$past(rd_sr_addr)] ^ $past(rd_byte)) & ~$past(bit_mask)) == 8'h00)
		else $error("bit operation disturbed other bits");
	chk_single_cycle: assert property (accept && !is_tbl |=> done_out && ready_out)
		else $error("byte access did not complete in one cycle");

	// refusal paths below are reached by the directed steps too; only the unmapped-bank read needs the random traffic
	sequence busy_table;
		!ready_out && pm_rd_out;
	endsequence

	chk_fetch_strobe: assert property (tbl_issue |=> busy_table ##1 !pm_rd_out)
		else $error("program fetch strobe not a single cycle");
	chk_bank_steer: assert property (accept && op_code_in == OP_READ
		&& addr_in > SR_END && bank_sel > LAST_BANK |=> rdata_out == ZERO_BYTE)
		else $error("unmapped bank read nonzero");
	chk_disp_limit: assert property (accept && op_code_in == OP_READ
		&& bank_sel == DISP_BANK && addr_in > DISP_END |=> rdata_out == ZERO_BYTE)
		else $error("read beyond display memory nonzero");
	chk_latch_no_store: assert property (accept && is_wr_op
		&& addr_in == {2'b00, ADDR_HIGH_LATCH} |=> $stable(high_byte_latch_out))
		else $error("store reached the high byte latch");
	chk_bank_write: assert property (accept && op_code_in == OP_WRITE
		&& addr_in == {2'b00, ADDR_BANK_SEL} |=> bank_select_out == $past(data_in))
		else $error("bank select not loaded by a store");
endmodule : bdm_core

/* tb/bdm_pm_model.sv */
// program memory stand-in answering table fetches
`timescale 1ns/10ps
module bdm_pm_model (
	// fetch request
	input  wire logic        clock_in,
	input  wire logic [13:0] pm_addr_in,
	input  wire logic        pm_rd_in,
	// fetched word
	output logic      [15:0] pm_data_out
);
	logic [15:0] junk_reg = 16'h1234;

	// outside a fetch the word keeps changing so a late sample shows up
	always @(posedge clock_in) begin
		junk_reg <= ~junk_reg + 16'h3C5B;
	end
	assign pm_data_out = pm_rd_in ? {pm_addr_in[13:6] ^ 8'h5A, pm_addr_in[7:0] + 8'h11}
		: junk_reg;
endmodule : bdm_pm_model

/* tb/bdm_core_tb_top.sv */
// self-checking bench for the banked data memory and table reads
`timescale 1ns/10ps
module bdm_core_tb_top;
	import bdm_pkg::*;
	logic        clock_in     = 1'b0;
	logic        srst_in      = 1'b1;
	logic        op_valid_in  = 1'b0;
	bdm_op_t     op_code_in   = OP_READ;
	logic [7:0]  addr_in      = 8'h00;
	logic [7:0]  data_in      = 8'h00;
	logic [2:0]  bit_in       = 3'h0;
	logic [13:0] pc_in        = 14'h0000;
	logic [6:0]  disp_addr_in = 7'h00;
	logic        ready_out, done_out, pm_rd_out;
	logic [7:0]  rdata_out, disp_data_out, bank_select_out, high_byte_latch_out;
	logic [13:0] pm_addr_out;
	logic [15:0] pm_data_in;
	int          fails        = 0;
	int          tests_run    = 0;
	logic [31:0] seed         = 32'h84F4;
	logic [7:0]  mem [0:7][0:255];
	logic [7:0]  sr [0:63];
	logic [7:0]  lat;
	logic [31:0] r;

	always #12.5 clock_in = ~clock_in;

	bdm_core DUT (.clock_in(clock_in), .srst_in(srst_in), .op_valid_in(op_valid_in),
		.op_code_in(op_code_in), .addr_in(addr_in), .data_in(data_in), .bit_in(bit_in),
		.pc_in(pc_in), .ready_out(ready_out), .done_out(done_out), .rdata_out(rdata_out),
		.pm_addr_out(pm_addr_out), .pm_rd_out(pm_rd_out), .pm_data_in(pm_data_in),
		.disp_addr_in(disp_addr_in), .disp_data_out(disp_data_out),
		.bank_select_out(bank_select_out), .high_byte_latch_out(high_byte_latch_out));

	bdm_pm_model PM (.clock_in(clock_in), .pm_addr_in(pm_addr_out), .pm_rd_in(pm_rd_out),
		.pm_data_out(pm_data_in));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		logic [7:0] bk;
		bk = sr[4];
		if (a <= 8'h3F) return (a == 8'h1F || a >= 8'h3E) ? 8'h00 : sr[a[5:0]];
		if (bk > 8'h06 || (bk == 8'h01 && a > 8'h9F)) return 8'h00;
		return mem[bk[2:0]][a];
	endfunction : exp_rd

	task automatic exp_wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] bk;
		bk = sr[4];
		if (a <= 8'h3F) begin
			if (a != 8'h08 && a != 8'h1F && a < 8'h3E) sr[a[5:0]] = v;
		end else if (bk <= 8'h06 && !(bk == 8'h01 && a > 8'h9F)) begin
			mem[bk[2:0]][a] = v;
		end
	endtask : exp_wr

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		if (fails == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict

	// called at a falling edge with the block idle
	task automatic do_op(input bdm_op_t c, input logic [7:0] a, input logic [7:0] d,
		input logic [2:0] b);
		int          k;
		logic        seen;
		logic [13:0] pa;
		logic [15:0] w;
		logic [7:0]  e;
		e = exp_rd(a);
		pa = {(c == OP_TBL_LAST) ? 6'h3F : pc_in[13:8], sr[7]};
		op_code_in = c;
		addr_in = a;
		data_in = d;
		bit_in = b;
		op_valid_in = 1'b1;
		@(negedge clock_in);
		op_valid_in = 1'b0;
		k = 0;
		seen = 1'b0;
		while (done_out !== 1'b1 && k < 4) begin
			if (pm_rd_out === 1'b1) begin
				seen = 1'b1;
				chk("pm_addr", {2'b00, pa}, {2'b00, pm_addr_out});
				chk("ready", 16'h0000, {15'h0, ready_out});
			end
			@(negedge clock_in);
			k++;
		end
		if (k == 4) begin
			fails++;
			print_verdict();
		end
		chk("latency", (c >= OP_TBL_CUR) ? 16'h0001 : 16'h0000, k[15:0]);
		chk("pm_rd", (c >= OP_TBL_CUR) ? 16'h0001 : 16'h0000, {15'h0, seen});
		chk("ready", 16'h0001, {15'h0, ready_out});
		case (c)
			OP_READ: chk("rdata", 16'(e), 16'(rdata_out));
			OP_WRITE: exp_wr(a, d);
			OP_SET: exp_wr(a, e | (8'h01 << b));
			OP_CLR: exp_wr(a, e & ~(8'h01 << b));
			default: begin
				w = {pa[13:6] ^ 8'h5A, pa[7:0] + 8'h11};
				exp_wr(a, w[7:0]);
				lat = w[15:8];
				sr[8] = lat;
			end
		endcase
		chk("latch", {8'h00, lat}, {8'h00, high_byte_latch_out});
		chk("bank", {8'h00, sr[4]}, {8'h00, bank_select_out});
		// idle cycle so valid is never dropped and raised in one step
		@(negedge clock_in);
	endtask : do_op

	initial begin
		repeat (4) @(negedge clock_in);
		srst_in = 1'b0;
		for (int i = 0; i < 64; i++) sr[i] = 8'h00;
		lat = 8'h00;
		chk("bank", 16'h0000, {8'h00, bank_select_out});
		// fill every bank so later reads have a known value
		for (int bk = 0; bk < 7; bk++) begin
			do_op(OP_WRITE, 8'h04, bk[7:0], 3'h0);
			for (int a = 64; a < 256; a++) do_op(OP_WRITE, a[7:0], 8'(xs() >> 8), 3'h0);
		end
		do_op(OP_WRITE, 8'h04, 8'h01, 3'h0);
		do_op(OP_WRITE, 8'h07, 8'hFF, 3'h0);
		do_op(OP_TBL_LAST, 8'hA0, 8'h00, 3'h0);
		do_op(OP_READ, 8'hA0, 8'h00, 3'h0);
		do_op(OP_TBL_CUR, 8'h9F, 8'h00, 3'h0);
		do_op(OP_READ, 8'h9F, 8'h00, 3'h0);
		do_op(OP_WRITE, 8'h08, 8'h3C, 3'h0);
		do_op(OP_SET, 8'h08, 8'h00, 3'h7);
		do_op(OP_READ, 8'h3E, 8'h00, 3'h0);
		for (int n = 0; n < 800; n++) begin
			r = xs();
			pc_in = r[13:0];
			if (r[23:21] == 3'h0) do_op(OP_WRITE, 8'h04, {5'h00, r[10:8]}, 3'h0);
			else do_op(bdm_op_t'(r[16:14] % 6), r[20] ? {2'b00, r[5:0]} : r[31:24],
				r[29:22], r[2:0]);
		end
		// mid-run reset: special registers clear, storage arrays keep their bytes
		do_op(OP_WRITE, 8'h04, 8'h03, 3'h0);
		srst_in = 1'b1;
		repeat (2) @(negedge clock_in);
		srst_in = 1'b0;
		for (int i = 0; i < 64; i++) sr[i] = 8'h00;
		lat = 8'h00;
		chk("bank", 16'h0000, {8'h00, bank_select_out});
		chk("latch", 16'h0000, {8'h00, high_byte_latch_out});
		for (int i = 0; i < 96; i++) begin
			disp_addr_in = i[6:0];
			@(negedge clock_in);
			chk("disp", {8'h00, mem[1][i + 64]}, {8'h00, disp_data_out});
		end
		print_verdict();
	end
endmodule : bdm_core_tb_top
